/* rtl/wake_watchdog_defs.svh */
// offsets, field positions, reset values and timing counts of the status and timer bank
`ifndef WAKE_WATCHDOG_DEFS_SVH
`define WAKE_WATCHDOG_DEFS_SVH

`define PATTERN_DATA_OFFSET    8'h70
`define WATCHDOG_JABBER_OFFSET 8'h78
`define SECONDARY_STAT_OFFSET  8'h80
`define SECONDARY_EN_OFFSET    8'h84

`define PATTERN_WORDS          25

`define WJ_RELEASE_BIT         5
`define WJ_RXWD_OFF_BIT        4
`define WJ_JAB_TIME_BIT        2
`define WJ_JAB_IMM_BIT         1
`define WJ_JAB_OFF_BIT         0
`define WJ_WRITE_MASK          32'h0000_0037

`define ST_TX_EARLY_BIT        31
`define ST_RX_EARLY_BIT        30
`define ST_XCVR_BIT            29
`define ST_TX_DEFER_BIT        28
`define ST_PAUSE_BIT           26
`define ST_BUS_ERR_LSB         23
`define ST_NORMAL_SUM_BIT      16
`define ST_ABNORMAL_SUM_BIT    15
`define ST_XCVR_RESET          1'b1
`define ST_ABNORMAL_RESET      1'b1

`define CLK_MHZ                250
`define BIT_NS_100             10
`define BIT_NS_10              100
`define RELEASE_SHORT_BITS     24
`define RELEASE_LONG_BITS      48
`define RX_WATCHDOG_BYTES      2560
`define JABBER_BYTES           2560
`define JABBER_US_100          2600
`define JABBER_US_10           26000
`define REENABLE_US_100        42000
`define REENABLE_US_10         420000
`define BIT_CYCLES_100         ((`BIT_NS_100 * `CLK_MHZ) / 1000)
`define BIT_CYCLES_10          ((`BIT_NS_10 * `CLK_MHZ) / 1000)
`define US_CYCLES              `CLK_MHZ

`endif

/* rtl/wake_watchdog_pkg.sv */
// types shared by the status and timer bank
package wake_watchdog_pkg;
    typedef enum logic [2:0] {
        BUS_ERR_PARITY = 3'h0,
        BUS_ERR_MASTER = 3'h1,
        BUS_ERR_TARGET = 3'h2
    } bus_error_kind_e;
    typedef enum {JAB_IDLE, JAB_COUNT, JAB_BLOCKED} jabber_state_e;
endpackage : wake_watchdog_pkg

/* rtl/wake_pattern_mem.sv */
// wake-up pattern store, 25 words, registered read data
`timescale 1ns/1ns
module wake_pattern_mem (
    input  wire logic        clk_in,      // core clock
    input  wire logic        wr_in,       // write one word
    input  wire logic [4:0]  waddr_in,    // write index
    input  wire logic [31:0] wdata_in,    // write word
    input  wire logic [4:0]  raddr_in,    // read index
    output logic      [31:0] rdata_out    // registered read word
);
    logic [31:0] mem [0:24];

    always_ff @(posedge clk_in) begin
        if (wr_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        rdata_out <= mem[raddr_in];
    end
endmodule : wake_pattern_mem

/* rtl/wake_watchdog_status_csrs.sv */
// control/status bank: wake pattern port, watchdog and jabber timers, secondary status
//
// What this block does
// - each record is four 32-bit mask words then one CRC16 plus offset word
// - the pattern offset field in each record is 8 bits wide
// - receive watchdog releases 24 or 48 bit-times after carrier drops
// - receive watchdog expires past 2560 bytes unless disabled
// - jabber cuts transmit after 2.6/26 ms, or 2560 byte-times when selected
// - after jabber, re-enable after 42/420 ms, or immediately when selected
// - jabber off bit removes jabber cut-off completely
// - rx early flag sets when enabled and first rx descriptor fills
// - early flags latch high and clear only on write of one
// - transceiver flag is OR of transceiver event bits 6..0, resets to one
// - tx deferred flag resets to zero and latches until cleared
// - pause flag sets on pause frame while pause function enabled
// - bus error kind: 000 parity, 001 master, 010 target; no event
// - bits 14..0 mirror the primary status register
// - bit 16 latches when any added normal event occurs
// - bit 15 latches when any added abnormal event occurs
`timescale 1ns/1ns
`include "wake_watchdog_defs.svh"
module wake_watchdog_status_csrs (
    input  wire logic                               CLK_IN,            // 250 MHz core clock
    input  wire logic                               RST_N_IN,          // sync reset, low
    input  wire logic [7:0]                         ADDR_IN,           // register byte address
    input  wire logic [31:0]                        WDATA_IN,          // write data
    input  wire logic                               WR_IN,             // write strobe
    input  wire logic                               RD_IN,             // read strobe
    output logic      [31:0]                        RDATA_OUT,         // read data, next cycle
    input  wire logic                               SPEED_100_IN,      // 1: 100 Mb/s line
    input  wire logic                               RX_CARRIER_IN,     // receive carrier sense
    input  wire logic                               RX_BYTE_IN,        // one received byte
    input  wire logic                               TX_ACTIVE_IN,      // transmitter sending
    output logic                                    RX_WATCHDOG_OUT,   // rx watchdog expired
    output logic                                    TX_BLOCKED_OUT,    // jabber holds tx off
    input  wire logic                               TX_TO_FIFO_IN,     // packet moved to tx fifo
    input  wire logic                               RX_FIRST_DESC_IN,  // first rx descriptor full
    input  wire logic                               TX_DEFERRED_IN,    // tx deferred event
    input  wire logic                               PAUSE_RX_IN,       // pause frame received
    input  wire logic                               PAUSE_ENABLE_IN,   // pause function on
    input  wire logic [6:0]                         XCVR_EVENTS_IN,    // transceiver event bits
    input  wire logic                               FATAL_BUS_ERR_IN,  // fatal bus error flag
    input  wire wake_watchdog_pkg::bus_error_kind_e BUS_ERR_KIND_IN,   // captured error kind
    input  wire logic [14:0]                        PRIMARY_STATUS_IN, // primary status bits
    input  wire logic                               ABNORMAL_EVENT_IN, // added abnormal event
    output logic [4:0]                              PATTERN_INDEX_OUT, // next pattern word
    output logic [31:0]                             PATTERN_WORD_OUT   // pattern word read
);
    import wake_watchdog_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic        wr_pat, wr_wj, wr_st, wr_en, rd_pat;
    logic [31:0] wj_r;
    logic        tx_early_en_r, rx_early_en_r;
    logic        tx_early_r, rx_early_r, tx_defer_r, pause_r, xcvr_r;
    logic        normal_sum_r, abnormal_sum_r;
    logic [2:0]  bus_err_r;
    logic [4:0]  pat_idx_r, pat_idx_nxt;
    logic [31:0] pat_rdata;
    logic        rd_pat_r;
    logic [31:0] rdata_nxt;

    assign wr_pat = WR_IN && (ADDR_IN == `PATTERN_DATA_OFFSET);
    assign wr_wj  = WR_IN && (ADDR_IN == `WATCHDOG_JABBER_OFFSET);
    assign wr_st  = WR_IN && (ADDR_IN == `SECONDARY_STAT_OFFSET);
    assign wr_en  = WR_IN && (ADDR_IN == `SECONDARY_EN_OFFSET);
    assign rd_pat = RD_IN && (ADDR_IN == `PATTERN_DATA_OFFSET);

    ////////////////////////////////////////////////////////////////////////////////////
    // wake pattern port: one index walks all 25 words, reads and writes alike
    // record k occupies words 5k..5k+4: mask 31:0 .. 127:96, then crc16/offset word
    assign pat_idx_nxt = (pat_idx_r == 5'(`PATTERN_WORDS - 1)) ? 5'h0 : pat_idx_r + 5'h1;

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            pat_idx_r <= 5'h0;
        end else if (wr_pat || rd_pat) begin
            pat_idx_r <= pat_idx_nxt;
        end
    end

    wake_pattern_mem u_mem (
        .clk_in    (CLK_IN),
        .wr_in     (wr_pat),
        .waddr_in  (pat_idx_r),
        .wdata_in  (WDATA_IN),
        .raddr_in  (pat_idx_r),
        .rdata_out (pat_rdata)
    );

    assign PATTERN_INDEX_OUT = pat_idx_r;
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            PATTERN_WORD_OUT <= 32'h0;
            rd_pat_r         <= 1'b0;
        end else begin
            PATTERN_WORD_OUT <= pat_rdata;
            rd_pat_r         <= rd_pat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            wj_r <= 32'h0;
        end else if (wr_wj) begin
            wj_r <= WDATA_IN & `WJ_WRITE_MASK;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            tx_early_en_r <= 1'b0;
            rx_early_en_r <= 1'b0;
        end else if (wr_en) begin
            tx_early_en_r <= WDATA_IN[`ST_TX_EARLY_BIT];
            rx_early_en_r <= WDATA_IN[`ST_RX_EARLY_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // line-rate unit pulses: bit, byte and microsecond
    logic [4:0] bit_cnt_r;
    logic [2:0] byte_cnt_r;
    logic [7:0] us_cnt_r;
    logic       bit_tick, byte_tick, us_tick;
    logic [4:0] bit_len;

    assign bit_len   = SPEED_100_IN ? 5'(`BIT_CYCLES_100) : 5'(`BIT_CYCLES_10);
    assign bit_tick  = (bit_cnt_r == bit_len - 5'h1);
    assign byte_tick = bit_tick && (byte_cnt_r == 3'h7);
    assign us_tick   = (us_cnt_r == 8'(`US_CYCLES - 1));

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            bit_cnt_r  <= 5'h0;
            byte_cnt_r <= 3'h0;
        end else if (bit_tick) begin
            bit_cnt_r  <= 5'h0;
            byte_cnt_r <= byte_cnt_r + 3'h1;
        end else begin
            bit_cnt_r <= bit_cnt_r + 5'h1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            us_cnt_r <= 8'h0;
        end else begin
            us_cnt_r <= us_tick ? 8'h0 : us_cnt_r + 8'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // receive watchdog: counts bytes, holds until carrier has been gone long enough
    logic [11:0] rx_bytes_r;
    logic [5:0]  rx_release_r;
    logic [5:0]  release_bits;

    assign release_bits = wj_r[`WJ_RELEASE_BIT] ? 6'(`RELEASE_LONG_BITS)
                                                : 6'(`RELEASE_SHORT_BITS);

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || wj_r[`WJ_RXWD_OFF_BIT]) begin
            rx_bytes_r      <= 12'h0;
            RX_WATCHDOG_OUT <= 1'b0;
            rx_release_r    <= 6'h0;
        end else if (RX_CARRIER_IN) begin
            rx_release_r <= 6'h0;
            if (RX_BYTE_IN && !RX_WATCHDOG_OUT) begin
                rx_bytes_r <= rx_bytes_r + 12'h1;
                if (rx_bytes_r >= 12'(`RX_WATCHDOG_BYTES)) begin
                    RX_WATCHDOG_OUT <= 1'b1;
                end
            end
        end else begin
            rx_bytes_r <= 12'h0;
            if (RX_WATCHDOG_OUT && bit_tick) begin
                if (rx_release_r == release_bits - 6'h1) begin
                    RX_WATCHDOG_OUT <= 1'b0;
                    rx_release_r    <= 6'h0;
                end else begin
                    rx_release_r <= rx_release_r + 6'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // jabber timer; microsecond tick keeps the long counts narrow
    jabber_state_e jab_state_r;
    logic [18:0]   jab_cnt_r;
    logic [18:0]   jab_limit, reenable_limit;
    logic          jab_tick;

    assign jab_tick  = wj_r[`WJ_JAB_TIME_BIT] ? byte_tick : us_tick;
    assign jab_limit = wj_r[`WJ_JAB_TIME_BIT] ? 19'(`JABBER_BYTES)
                     : (SPEED_100_IN ? 19'(`JABBER_US_100) : 19'(`JABBER_US_10));
    assign reenable_limit = SPEED_100_IN ? 19'(`REENABLE_US_100) : 19'(`REENABLE_US_10);
    assign TX_BLOCKED_OUT = (jab_state_r == JAB_BLOCKED);

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN || wj_r[`WJ_JAB_OFF_BIT]) begin
            jab_state_r <= JAB_IDLE;
            jab_cnt_r   <= 19'h0;
        end else begin
            unique case (jab_state_r)
                JAB_IDLE: begin
                    jab_cnt_r <= 19'h0;
                    if (TX_ACTIVE_IN) begin
                        jab_state_r <= JAB_COUNT;
                    end
                end
                JAB_COUNT: begin
                    if (!TX_ACTIVE_IN) begin
                        jab_state_r <= JAB_IDLE;
                    end else if (jab_cnt_r >= jab_limit) begin
                        // cut off for one cycle at least, even on immediate re-enable
                        jab_cnt_r   <= 19'h0;
                        jab_state_r <= JAB_BLOCKED;
                    end else if (jab_tick) begin
                        jab_cnt_r <= jab_cnt_r + 19'h1;
                    end
                end
                JAB_BLOCKED: begin
                    if (wj_r[`WJ_JAB_IMM_BIT] || jab_cnt_r >= reenable_limit) begin
                        jab_state_r <= JAB_IDLE;
                    end else if (us_tick) begin
                        jab_cnt_r <= jab_cnt_r + 19'h1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // secondary status flags: set wins over a same-cycle write-one clear
    logic tx_early_set, rx_early_set, xcvr_set, normal_set;

    assign tx_early_set = tx_early_en_r && TX_TO_FIFO_IN;
    assign rx_early_set = rx_early_en_r && RX_FIRST_DESC_IN;
    assign xcvr_set     = |XCVR_EVENTS_IN;
    assign normal_set   = tx_early_set || rx_early_set || xcvr_set
                       || TX_DEFERRED_IN || (PAUSE_RX_IN && PAUSE_ENABLE_IN);

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            tx_early_r <= 1'b0;
            rx_early_r <= 1'b0;
        end else begin
            tx_early_r <= tx_early_set
                       || (tx_early_r && !(wr_st && WDATA_IN[`ST_TX_EARLY_BIT]));
            rx_early_r <= rx_early_set
                       || (rx_early_r && !(wr_st && WDATA_IN[`ST_RX_EARLY_BIT]));
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            xcvr_r <= `ST_XCVR_RESET;
        end else begin
            xcvr_r <= xcvr_set || (xcvr_r && !(wr_st && WDATA_IN[`ST_XCVR_BIT]));
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            tx_defer_r <= 1'b0;
            pause_r    <= 1'b0;
        end else begin
            tx_defer_r <= TX_DEFERRED_IN
                       || (tx_defer_r && !(wr_st && WDATA_IN[`ST_TX_DEFER_BIT]));
            pause_r    <= (PAUSE_RX_IN && PAUSE_ENABLE_IN)
                       || (pause_r && !(wr_st && WDATA_IN[`ST_PAUSE_BIT]));
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            normal_sum_r   <= 1'b0;
            abnormal_sum_r <= `ST_ABNORMAL_RESET;
        end else begin
            normal_sum_r   <= normal_set
                           || (normal_sum_r && !(wr_st && WDATA_IN[`ST_NORMAL_SUM_BIT]));
            abnormal_sum_r <= ABNORMAL_EVENT_IN
                           || (abnormal_sum_r
                               && !(wr_st && WDATA_IN[`ST_ABNORMAL_SUM_BIT]));
        end
    end

    // error kind tracks the captured value only while the fatal flag stands
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            bus_err_r <= BUS_ERR_PARITY;
        end else if (FATAL_BUS_ERR_IN) begin
            bus_err_r <= BUS_ERR_KIND_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h0;
        unique case (ADDR_IN)
            `WATCHDOG_JABBER_OFFSET: rdata_nxt = wj_r;
            `SECONDARY_STAT_OFFSET: begin
                rdata_nxt[`ST_TX_EARLY_BIT]     = tx_early_r;
                rdata_nxt[`ST_RX_EARLY_BIT]     = rx_early_r;
                rdata_nxt[`ST_XCVR_BIT]         = xcvr_r;
                rdata_nxt[`ST_TX_DEFER_BIT]     = tx_defer_r;
                rdata_nxt[`ST_PAUSE_BIT]        = pause_r;
                rdata_nxt[`ST_BUS_ERR_LSB +: 3] = bus_err_r;
                rdata_nxt[`ST_NORMAL_SUM_BIT]   = normal_sum_r;
                rdata_nxt[`ST_ABNORMAL_SUM_BIT] = abnormal_sum_r;
                rdata_nxt[14:0]                 = PRIMARY_STATUS_IN;
            end
            `SECONDARY_EN_OFFSET: begin
                rdata_nxt[`ST_TX_EARLY_BIT] = tx_early_en_r;
                rdata_nxt[`ST_RX_EARLY_BIT] = rx_early_en_r;
            end
            default: rdata_nxt = 32'h0;
        endcase
    end

    // pattern reads come from the memory's registered port a cycle later
    logic [31:0] rdata_hold_r;
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            rdata_hold_r <= 32'h0;
        end else begin
            rdata_hold_r <= RD_IN ? rdata_nxt : 32'h0;
        end
    end
    assign RDATA_OUT = rd_pat_r ? pat_rdata : rdata_hold_r;

endmodule : wake_watchdog_status_csrs

/* verification/wake_watchdog_status_csrs_asserts.sv */
// port-level assertions for the status and timer bank
`timescale 1ns/1ns
module wake_watchdog_status_csrs_asserts (
    input wire logic                               CLK_IN,            // clock
    input wire logic                               RST_N_IN,          // reset
    input wire logic [7:0]                         ADDR_IN,           // address
    input wire logic [31:0]                        WDATA_IN,          // write data
    input wire logic                               WR_IN,             // write
    input wire logic                               RD_IN,             // read
    input wire logic [31:0]                        RDATA_OUT,         // read data
    input wire logic                               RX_WATCHDOG_OUT,   // watchdog
    input wire logic                               TX_BLOCKED_OUT,    // jabber block
    input wire logic                               TX_TO_FIFO_IN,     // tx event
    input wire logic                               RX_FIRST_DESC_IN,  // rx event
    input wire logic                               TX_DEFERRED_IN,    // deferred
    input wire logic                               PAUSE_RX_IN,       // pause frame
    input wire logic                               PAUSE_ENABLE_IN,   // pause on
    input wire logic [6:0]                         XCVR_EVENTS_IN,    // xcvr bits
    input wire logic                               FATAL_BUS_ERR_IN,  // fatal error
    input wire wake_watchdog_pkg::bus_error_kind_e BUS_ERR_KIND_IN,   // error kind
    input wire logic [14:0]                        PRIMARY_STATUS_IN, // mirror source
    input wire logic                               ABNORMAL_EVENT_IN, // abnormal
    input wire logic [4:0]                         PATTERN_INDEX_OUT  // pattern index
);
    import wake_watchdog_pkg::*;
    logic [31:0] ctl_r;
    logic [1:0]  en_r;
    logic        rd_stat;
    ////////////////////////////////////////
    // software copy of control and enables
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            ctl_r <= 32'h0;
            en_r  <= 2'h0;
        end else if (WR_IN && ADDR_IN == 8'h78) begin
            ctl_r <= WDATA_IN;
        end else if (WR_IN && ADDR_IN == 8'h84) begin
            en_r <= WDATA_IN[31:30];
        end
    end
    assign rd_stat = RD_IN && ADDR_IN == 8'h80;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    AST_RD_IDLE: assert property (!RD_IN |=> RDATA_OUT == 32'h0)
        else $error("read data not idle");
    AST_PAT_STEP: assert property ((WR_IN || RD_IN) && ADDR_IN == 8'h70 &&
        PATTERN_INDEX_OUT != 5'd24 |=> PATTERN_INDEX_OUT == $past(PATTERN_INDEX_OUT) + 5'd1)
        else $error("pattern index did not advance");
    AST_PAT_WRAP: assert property ((WR_IN || RD_IN) && ADDR_IN == 8'h70 &&
        PATTERN_INDEX_OUT == 5'd24 |=> PATTERN_INDEX_OUT == 5'd0)
        else $error("pattern index did not wrap");
    AST_WD_OFF: assert property (ctl_r[4] |-> ##1 !RX_WATCHDOG_OUT)
        else $error("watchdog active while disabled");
    AST_JAB_OFF: assert property (ctl_r[0] |-> ##1 !TX_BLOCKED_OUT)
        else $error("jabber block while disabled");
    AST_TX_EARLY: assert property (TX_TO_FIFO_IN && en_r[1] ##2 rd_stat |=> RDATA_OUT[31])
        else $error("tx early flag missing");
    AST_RX_EARLY: assert property (RX_FIRST_DESC_IN && en_r[0] ##2 rd_stat |=> RDATA_OUT[30])
        else $error("rx early flag missing");
    AST_DEFER: assert property (TX_DEFERRED_IN ##2 rd_stat |=> RDATA_OUT[28] && RDATA_OUT[16])
        else $error("deferred flag or summary missing");
    AST_PAUSE: assert property (PAUSE_RX_IN && PAUSE_ENABLE_IN ##2 rd_stat |=> RDATA_OUT[26])
        else $error("pause flag missing");
    AST_ABNORMAL: assert property (ABNORMAL_EVENT_IN ##2 rd_stat |=> RDATA_OUT[15])
        else $error("abnormal summary missing");
    AST_XCVR: assert property (rd_stat && $past(XCVR_EVENTS_IN) != 7'h0 |=> RDATA_OUT[29])
        else $error("transceiver flag missing");
    AST_MIRROR: assert property (rd_stat |=> RDATA_OUT[14:0] == $past(PRIMARY_STATUS_IN))
        else $error("primary mirror mismatch");
    AST_BUS_KIND: assert property (rd_stat && $past(FATAL_BUS_ERR_IN) |=>
        RDATA_OUT[25:23] == $past(BUS_ERR_KIND_IN, 2))
        else $error("bus error kind mismatch");
    COV_WD: cover property ($rose(RX_WATCHDOG_OUT));
    COV_JAB: cover property ($rose(TX_BLOCKED_OUT));
    COV_WRAP: cover property (WR_IN && ADDR_IN == 8'h70 && PATTERN_INDEX_OUT == 5'd24);
endmodule : wake_watchdog_status_csrs_asserts

bind wake_watchdog_status_csrs wake_watchdog_status_csrs_asserts chk_u (
    .CLK_IN, .RST_N_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .RX_WATCHDOG_OUT,
    .TX_BLOCKED_OUT, .TX_TO_FIFO_IN, .RX_FIRST_DESC_IN, .TX_DEFERRED_IN, .PAUSE_RX_IN,
    .PAUSE_ENABLE_IN, .XCVR_EVENTS_IN, .FATAL_BUS_ERR_IN, .BUS_ERR_KIND_IN,
    .PRIMARY_STATUS_IN, .ABNORMAL_EVENT_IN, .PATTERN_INDEX_OUT);

/* verification/tb_wake_watchdog_status_csrs.sv */
// self-checking bench for the status and timer bank
`timescale 1ns/1ns
module tb_wake_watchdog_status_csrs;
    import wake_watchdog_pkg::*;
    logic            clk, rst_n, wr, rd, spd, car, byt, txa, t2f, rfd, tdf, prx, pen, fat, abn;
    logic            wdo, tbl;
    logic [7:0]      addr;
    logic [31:0]     wdata, rdata, rv;
    logic [6:0]      xev;
    logic [14:0]     pst;
    logic [4:0]      pidx;
    bus_error_kind_e kind;
    int              err_total, n_checks;
    wake_watchdog_status_csrs dut_u (
        .CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .SPEED_100_IN(spd), .RX_CARRIER_IN(car),
        .RX_BYTE_IN(byt), .TX_ACTIVE_IN(txa), .RX_WATCHDOG_OUT(wdo), .TX_BLOCKED_OUT(tbl),
        .TX_TO_FIFO_IN(t2f), .RX_FIRST_DESC_IN(rfd), .TX_DEFERRED_IN(tdf), .PAUSE_RX_IN(prx),
        .PAUSE_ENABLE_IN(pen), .XCVR_EVENTS_IN(xev), .FATAL_BUS_ERR_IN(fat),
        .BUS_ERR_KIND_IN(kind), .PRIMARY_STATUS_IN(pst), .ABNORMAL_EVENT_IN(abn),
        .PATTERN_INDEX_OUT(pidx), .PATTERN_WORD_OUT());
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr32
    task automatic rd32(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd32
    task automatic t_reset;
        rd32(8'h80, rv);
        chk("status reset", rv, 32'h2000_8000);
        rd32(8'h90, rv);
        chk("unmapped read", rv, 32'h0);
        wr32(8'h78, 32'hffff_ffff);
        rd32(8'h78, rv);
        chk("control mask", rv, 32'h0000_0037);
        $display("test reset done");
    endtask : t_reset
    task automatic t_pattern;
        for (int i = 0; i < 50; i++) begin
            if (i < 25) begin
                wr32(8'h70, {8'(i), 8'ha5, 8'h00, 8'(i + 1)});
            end else begin
                rd32(8'h70, rv);
                chk("pattern word", rv, {8'(i - 25), 8'ha5, 8'h00, 8'(i - 24)});
            end
            chk("pattern index", {27'h0, pidx}, (i + 1) % 25);
        end
        $display("test pattern done");
    endtask : t_pattern
    task automatic t_events(input logic on);
        wr32(8'h84, {on, on, 30'h0});
        @(posedge clk);
        {pen, t2f, rfd, tdf, prx, abn} <= {on, 4'hf, on, 1'b1};
        @(posedge clk);
        {t2f, rfd, tdf, prx, abn} <= 5'h0;
        rd32(8'h80, rv);
        chk("flags set", rv & 32'hfffe_ffff, on ? 32'hf400_8000 : 32'h1000_8000);
        chk("normal summary", rv[16], 1'b1);
        wr32(8'h80, 32'h0);
        rd32(8'h80, rv);
        chk("write zero", rv & 32'hfffe_ffff, on ? 32'hf400_8000 : 32'h1000_8000);
        wr32(8'h80, 32'hffff_ffff);
        rd32(8'h80, rv);
        chk("write one", rv, 32'h0);
        $display("test events done");
    endtask : t_events
    task automatic t_xcvr;
        @(posedge clk);
        {xev, fat, pst} <= {7'h40, 1'b1, 15'h5a5a};
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            kind <= bus_error_kind_e'(k);
            rd32(8'h80, rv);
            chk("bus error kind", rv[25:23], k);
            chk("xcvr and mirror", rv & 32'h2000_7fff, 32'h2000_5a5a);
        end
        @(posedge clk);
        {xev, fat} <= 8'h0;
        wr32(8'h80, 32'h2000_0000);
        rd32(8'h80, rv);
        chk("xcvr cleared", rv[29], 32'h0);
        $display("test xcvr done");
    endtask : t_xcvr
    task automatic t_rxwd(input logic rel, input logic off);
        wr32(8'h78, {26'h0, rel, off, 4'h0});
        car <= 1'b1;
        for (int n = 0; n < 2560; n++) begin
            byt <= 1'b1;
            @(posedge clk);
            byt <= 1'b0;
            @(posedge clk);
        end
        #1 chk("watchdog at limit", wdo, 32'h0);
        byt <= 1'b1;
        @(posedge clk);
        byt <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("watchdog expired", wdo, !off);
        car <= 1'b0;
        // 24 bit-times span 48 cycles at 2 cycles per bit, 48 bit-times span 96
        repeat (rel ? 90 : 40) @(posedge clk);
        #1 chk("watchdog held", wdo, !off);
        repeat (40) @(posedge clk);
        #1 chk("watchdog released", wdo, 32'h0);
        $display("test rx watchdog done");
    endtask : t_rxwd
    task automatic t_jabber;
        int n;
        wr32(8'h78, 32'h0000_0006);
        txa <= 1'b1;
        n = 0;
        while (tbl !== 1'b1 && n < 60000) begin
            @(posedge clk);
            #1 n++;
        end
        chk("jabber cut-off window", n >= 40000 && n <= 52000, 32'h1);
        repeat (3) @(posedge clk);
        #1 chk("jabber re-enable", tbl, 32'h0);
        wr32(8'h78, 32'h0000_0001);
        repeat (200) @(posedge clk);
        #1 chk("jabber off", tbl, 32'h0);
        txa <= 1'b0;
        $display("test jabber done");
    endtask : t_jabber
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // run needs about 60k cycles
    initial begin
        #400000;
        err_total++;
        close_out;
    end
    initial begin
        {rst_n, wr, rd, car, byt, txa, t2f, rfd, tdf, prx, pen, fat, abn} = 13'h0;
        {addr, wdata, xev, pst} = 62'h0;
        kind = BUS_ERR_PARITY;
        spd = 1'b1;
        err_total = 0;
        n_checks = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_pattern;
        t_events(1'b1);
        t_events(1'b0);
        t_xcvr;
        t_rxwd(1'b0, 1'b0);
        t_rxwd(1'b1, 1'b0);
        t_rxwd(1'b0, 1'b1);
        t_jabber;
        close_out;
    end
endmodule : tb_wake_watchdog_status_csrs
